// *** logic/halt_clock_stop_control.sv ***
// How it works
// [RULE1] A high chip enable level releases clock stop and issues an enable reset.
// [RULE2] A supply dip to 2.2 V followed by a rise to 4.5 V gives a power-on reset that also releases clock stop.
// [RULE3] Leaving clock stop by power-on reset switches the power failure detector back on.
// [RULE4] The stop instruction takes effect only while the synchronised chip enable is low.
// [RULE5] A stop seen with chip enable high is a no-operation and execution carries on.
// [RULE6] After an ignored stop with chip enable still high, the enable reset fires on the next basic timer 0 carry.
// [RULE7] Halt stops instruction execution while the peripherals keep running.
// [RULE8] Clock stop halts every peripheral.
// [RULE9] Halt leaves control registers alone, while a valid stop loads their initial values.
// [RULE10] A serial transfer carries on through halt, and the serial 0 interrupt acceptance ends halt.
// [RULE11] Entering clock stop aborts any serial transfer and forces port 0A to input mode.
// [RULE12] A valid stop turns the crystal oscillator off, removing core and peripheral clocks.
// [RULE13] Software passes operand 000B with the stop instruction.
// [RULE14] During clock stop the power failure detector stays off even at 2.2 V supply.
// [RULE15] The chip enable pin is synchronised before any decision uses it.
`timescale 1ns/1ps

module halt_clock_stop_control (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic chip_enable,
  input  wire logic halt_req,
  input  wire logic stop_req,
  input  wire logic halt_release_event,
  input  wire logic serial0_irq_accept,
  input  wire logic serial0_transfer_trigger,
  input  wire logic serial0_done,
  input  wire logic btm0_carry_set,
  input  wire logic vdd_low,
  input  wire logic vdd_ok,
  output logic      cpu_run_q,
  output logic      periph_run_q,
  output logic      osc_en_q,
  output logic      ctrl_init_q,
  output logic      serial_abort_q,
  output logic      serial0_active_q,
  output logic      port_zero_a_input_q,
  output logic      enable_reset_q,
  output logic      power_on_reset_q,
  output logic      pfd_en_q,
  output logic      power_fail,
  output logic      stop_nop_q,
  output logic      halt_state_q,
  output logic      stop_state_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  standby_pkg::standby_state_t state_q;
  standby_pkg::standby_state_t state_d;

  logic ce_meta_q;
  logic ce_sync_q;
  logic por_pulse;

  logic in_run;
  logic in_halt;
  logic in_stop;
  logic in_wait;
  logic stop_valid;
  logic stop_ignored;
  logic halt_release;
  logic stop_enter;
  logic nop_event;
  logic ce_reset_stop;
  logic ce_reset_wait;
  logic serial_start;

  logic cpu_run_d;
  logic periph_run_d;
  logic enable_reset_d;
  logic pfd_en_d;
  logic serial0_active_d;

  ////////////////////////////////////////////////////////////////////////////
  // Chip enable synchroniser; only the second stage is looked at

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ce_meta_q <= standby_pkg::RST_CE_SYNC;
      ce_sync_q <= standby_pkg::RST_CE_SYNC;
    end else begin
      ce_meta_q <= chip_enable; // RULE15
      ce_sync_q <= ce_meta_q; // RULE15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Supply watch: power-on reset and power failure detection

  supply_monitor u_supply (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .vdd_low    (vdd_low),
    .vdd_ok     (vdd_ok),
    .pfd_enable (pfd_en_q),
    .por_pulse  (por_pulse),
    .power_fail (power_fail)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  assign in_run  = (state_q == standby_pkg::ST_RUN);
  assign in_halt = (state_q == standby_pkg::ST_HALT);
  assign in_stop = (state_q == standby_pkg::ST_STOP);
  assign in_wait = (state_q == standby_pkg::ST_WAIT);

  // Operand is trusted to be the stop symbol; not checked here
  assign stop_valid    = in_run & stop_req & ~ce_sync_q; // RULE4
  assign stop_ignored  = in_run & stop_req & ce_sync_q; // RULE5
  assign halt_release  = serial0_irq_accept | halt_release_event; // RULE10
  assign stop_enter    = stop_valid & ~por_pulse;
  assign nop_event     = stop_ignored & ~por_pulse; // RULE5
  assign ce_reset_stop = in_stop & ce_sync_q & ~por_pulse; // RULE1
  assign ce_reset_wait = in_wait & ce_sync_q & btm0_carry_set & ~por_pulse; // RULE6
  // Only a running core can execute the trigger instruction
  assign serial_start  = serial0_transfer_trigger & (in_run | in_wait);

  ////////////////////////////////////////////////////////////////////////////
  // State machine

  always_comb begin
    state_d = state_q;
    case (state_q)
      standby_pkg::ST_RUN: begin
        if (stop_valid) begin
          state_d = standby_pkg::ST_STOP; // RULE4
        end else if (stop_ignored) begin
          state_d = standby_pkg::ST_WAIT; // RULE5
        end else if (halt_req) begin
          state_d = standby_pkg::ST_HALT; // RULE7
        end
      end
      standby_pkg::ST_HALT: begin
        if (halt_release) begin
          state_d = standby_pkg::ST_RUN; // RULE10
        end
      end
      standby_pkg::ST_STOP: begin
        if (ce_sync_q) begin
          state_d = standby_pkg::ST_RUN; // RULE1
        end
      end
      standby_pkg::ST_WAIT: begin
        // Chip enable dropping again hands control back to the program
        if (!ce_sync_q || btm0_carry_set) begin
          state_d = standby_pkg::ST_RUN; // RULE6
        end
      end
      default: begin
        state_d = standby_pkg::ST_RUN;
      end
    endcase
    if (por_pulse) begin
      state_d = standby_pkg::ST_RUN; // RULE2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next values of the outputs

  assign cpu_run_d      = (state_d == standby_pkg::ST_RUN) | (state_d == standby_pkg::ST_WAIT); // RULE7
  assign periph_run_d   = (state_d != standby_pkg::ST_STOP); // RULE8
  assign enable_reset_d = ce_reset_stop | ce_reset_wait;
  // Only power-on reset re-arms the detector; a chip enable exit leaves it off
  assign pfd_en_d       = por_pulse | (pfd_en_q & ~stop_enter); // RULE3 RULE14
  // Abort beats a same-cycle start; a start beats a same-cycle done
  assign serial0_active_d = ~stop_enter & (serial_start | (serial0_active_q & ~serial0_done)); // RULE11 RULE10

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= standby_pkg::RST_STATE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cpu_run_q    <= standby_pkg::RST_CPU_RUN;
      periph_run_q <= standby_pkg::RST_PERIPH_RUN;
      osc_en_q     <= standby_pkg::RST_OSC_EN;
      halt_state_q <= standby_pkg::RST_STATE_FLAG;
      stop_state_q <= standby_pkg::RST_STATE_FLAG;
    end else begin
      cpu_run_q    <= cpu_run_d;
      periph_run_q <= periph_run_d; // RULE8
      osc_en_q     <= periph_run_d; // RULE12
      halt_state_q <= (state_d == standby_pkg::ST_HALT);
      stop_state_q <= (state_d == standby_pkg::ST_STOP);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_init_q      <= standby_pkg::RST_PULSE;
      serial_abort_q   <= standby_pkg::RST_PULSE;
      enable_reset_q   <= standby_pkg::RST_PULSE;
      power_on_reset_q <= standby_pkg::RST_PULSE;
      stop_nop_q       <= standby_pkg::RST_PULSE;
    end else begin
      ctrl_init_q      <= stop_enter; // RULE9
      serial_abort_q   <= stop_enter; // RULE11
      enable_reset_q   <= enable_reset_d; // RULE1 RULE6
      power_on_reset_q <= por_pulse; // RULE2
      stop_nop_q       <= nop_event; // RULE5
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pfd_en_q            <= standby_pkg::RST_PFD_EN;
      serial0_active_q    <= standby_pkg::RST_SERIAL_ACT;
      port_zero_a_input_q <= standby_pkg::RST_PORT_ZERO_A_INPUT;
    end else begin
      pfd_en_q            <= pfd_en_d;
      serial0_active_q    <= serial0_active_d;
      port_zero_a_input_q <= (state_d == standby_pkg::ST_STOP); // RULE11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  stop_needs_low_a: assert property ( // RULE4
    $rose(stop_state_q) |-> !$past(ce_sync_q) && $past(stop_req))
    else $error("clock stop entered with chip enable high");

  stop_as_nop_a: assert property ( // RULE5
    (in_run && stop_req && ce_sync_q && !por_pulse) |=> stop_nop_q && cpu_run_q && !stop_state_q)
    else $error("ignored stop did not act as a no-operation");

  ce_release_a: assert property ( // RULE1
    (in_stop && ce_sync_q && !por_pulse) |=> enable_reset_q && osc_en_q && cpu_run_q && !stop_state_q)
    else $error("chip enable high did not release clock stop");

  carry_reset_a: assert property ( // RULE6
    (in_wait && ce_sync_q && !btm0_carry_set && !por_pulse) |=> !enable_reset_q ##0 in_wait)
    else $error("enable reset fired before the timer carry");

  carry_fires_a: assert property ( // RULE6
    (in_wait && ce_sync_q && btm0_carry_set && !por_pulse) |=> enable_reset_q && in_run)
    else $error("timer carry did not give the enable reset");

  halt_keeps_periph_a: assert property ( // RULE7
    $rose(halt_state_q) |-> periph_run_q && !cpu_run_q && !ctrl_init_q && $past(cpu_run_q))
    else $error("halt entry stopped peripherals or reloaded controls");

  stop_clock_off_a: assert property ( // RULE8
    stop_state_q |-> !osc_en_q && !periph_run_q && !cpu_run_q)
    else $error("clocks running during clock stop");

  stop_init_regs_a: assert property ( // RULE9
    $rose(stop_state_q) |-> ctrl_init_q && serial_abort_q && port_zero_a_input_q && !serial0_active_q)
    else $error("stop entry did not reload controls or abort serial");

  halt_serial_a: assert property ( // RULE10
    (in_halt && serial0_active_q && !serial0_done && !serial0_irq_accept && !halt_release_event && !por_pulse)
      |=> serial0_active_q && halt_state_q)
    else $error("serial transfer lost during halt");

  halt_irq_exit_a: assert property ( // RULE10
    (in_halt && serial0_irq_accept) |=> cpu_run_q && !halt_state_q)
    else $error("serial interrupt did not end halt");

  por_exit_a: assert property ( // RULE3
    (por_pulse && in_stop) |=> power_on_reset_q && pfd_en_q && !stop_state_q)
    else $error("power-on reset did not restore detector");

  pfd_quiet_a: assert property ( // RULE14
    stop_state_q |-> !pfd_en_q ##1 !power_fail)
    else $error("power failure detection active during clock stop");

  ce_sync_delay_a: assert property ( // RULE15
    $past(nrst) && $past(nrst, 2) |-> ce_sync_q == $past(chip_enable, standby_pkg::SYNC_LATENCY))
    else $error("chip enable not two stages delayed");

  wait_ce_drop_a: assert property ( // RULE6
    (in_wait && !ce_sync_q && !por_pulse) |=> !enable_reset_q && in_run)
    else $error("chip enable drop in wait gave an enable reset");

  halt_regs_kept_a: assert property ( // RULE9
    halt_state_q |-> !ctrl_init_q && !serial_abort_q && periph_run_q)
    else $error("control registers reloaded during halt");

  stop_osc_off_a: assert property ( // RULE12
    $rose(stop_state_q) |-> $fell(osc_en_q) && !cpu_run_q)
    else $error("stop entry left the oscillator running");

  stop_port_input_a: assert property ( // RULE11
    stop_state_q |-> port_zero_a_input_q && !serial0_active_q)
    else $error("port 0A or serial active during clock stop");

  por_pfd_on_a: assert property ( // RULE3
    $rose(power_on_reset_q) |-> pfd_en_q && !stop_state_q && !halt_state_q)
    else $error("power-on reset left the detector off");

endmodule // halt_clock_stop_control

// *** logic/standby_pkg.sv ***
package standby_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Standby states, Gray coded along run <-> halt and run <-> stop

  typedef enum logic [1:0] {
    ST_RUN  = 2'h0,
    ST_HALT = 2'h1,
    ST_STOP = 2'h2,
    ST_WAIT = 2'h3
  } standby_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values

  localparam standby_state_t RST_STATE       = ST_RUN;
  localparam logic           RST_CE_SYNC     = 1'h0;
  localparam logic           RST_CPU_RUN     = 1'h1;
  localparam logic           RST_PERIPH_RUN  = 1'h1;
  localparam logic           RST_OSC_EN      = 1'h1;
  localparam logic           RST_PULSE       = 1'h0;
  localparam logic           RST_PFD_EN      = 1'h1;
  localparam logic           RST_PORT_ZERO_A_INPUT = 1'h0;
  localparam logic           RST_SERIAL_ACT  = 1'h0;
  localparam logic           RST_STATE_FLAG  = 1'h0;
  localparam logic           RST_POR_ARMED   = 1'h0;
  localparam logic           RST_POWER_FAIL  = 1'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Timing counts, in core_clk cycles

  localparam int SYNC_LATENCY = 2;

endpackage

// *** logic/supply_monitor.sv ***
`timescale 1ns/1ps

module supply_monitor (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic vdd_low,
  input  wire logic vdd_ok,
  input  wire logic pfd_enable,
  output logic      por_pulse,
  output logic      power_fail
);

  logic armed_q;
  logic armed_d;
  logic por_d;
  logic fail_d;

  ////////////////////////////////////////////////////////////////////////////
  // Power-on reset needs a dip to the low level, then a climb to the high one

  assign por_d   = armed_q & vdd_ok & ~vdd_low; // RULE2
  assign armed_d = vdd_low | (armed_q & ~por_d); // RULE2
  // Detector gated off during clock stop so memory can be held at low supply
  assign fail_d  = pfd_enable & vdd_low; // RULE14

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      armed_q    <= standby_pkg::RST_POR_ARMED;
      por_pulse  <= standby_pkg::RST_PULSE;
      power_fail <= standby_pkg::RST_POWER_FAIL;
    end else begin
      armed_q    <= armed_d;
      por_pulse  <= por_d;
      power_fail <= fail_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  por_after_dip_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE2
    $rose(por_pulse) |-> $past(armed_q) && $past(vdd_ok))
    else $error("power-on reset without prior supply dip");

  fail_gated_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE14
    !pfd_enable |=> !power_fail)
    else $error("power fail flagged while detector disabled");

endmodule // supply_monitor

// *** testbench/ce_controller.sv ***
`timescale 1ns/1ps

module ce_controller (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       ce_req,
  input  wire logic [3:0] ce_delay,
  output logic            chip_enable
);
  logic [3:0] wait_q;

  // A slow controller settles the pin late; the level then holds
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wait_q      <= 4'h0;
      chip_enable <= 1'h0;
    end else if (ce_req == chip_enable) wait_q <= 4'h0;
    else if (wait_q >= ce_delay) chip_enable <= ce_req;
    else wait_q <= wait_q + 4'h1;
  end
endmodule // ce_controller

// *** testbench/halt_clock_stop_control_tb.sv ***
`timescale 1ns/1ps

module halt_clock_stop_control_tb;
  logic       core_clk = 1'h0;
  logic       nrst = 1'h0;
  logic       ce_req = 1'h0;
  logic [3:0] ce_delay = 4'h0;
  logic       chip_enable;
  logic       halt_req = 1'h0, stop_req = 1'h0, halt_release_event = 1'h0;
  logic       serial0_irq_accept = 1'h0, serial0_transfer_trigger = 1'h0;
  logic       serial0_done = 1'h0, btm0_carry_set = 1'h0;
  logic       vdd_low = 1'h0, vdd_ok = 1'h1;
  logic       cpu_run_q, periph_run_q, osc_en_q, ctrl_init_q, serial_abort_q;
  logic       serial0_active_q, port_zero_a_input_q, enable_reset_q, power_on_reset_q;
  logic       pfd_en_q, power_fail, stop_nop_q, halt_state_q, stop_state_q;
  logic [7:0] n_ctrl = 8'h0, n_abort = 8'h0, n_ereset = 8'h0, n_por = 8'h0, n_nop = 8'h0;
  logic [6:0] lv;
  int         mismatches = 0;
  int         n_checks = 0;

  always #20 core_clk = ~core_clk;

  ce_controller u_ce (.core_clk(core_clk), .nrst(nrst), .ce_req(ce_req), .ce_delay(ce_delay),
                      .chip_enable(chip_enable));

  halt_clock_stop_control u_dut (
    .core_clk(core_clk), .nrst(nrst), .chip_enable(chip_enable), .halt_req(halt_req),
    .stop_req(stop_req), .halt_release_event(halt_release_event),
    .serial0_irq_accept(serial0_irq_accept), .serial0_transfer_trigger(serial0_transfer_trigger),
    .serial0_done(serial0_done), .btm0_carry_set(btm0_carry_set), .vdd_low(vdd_low),
    .vdd_ok(vdd_ok), .cpu_run_q(cpu_run_q), .periph_run_q(periph_run_q), .osc_en_q(osc_en_q),
    .ctrl_init_q(ctrl_init_q), .serial_abort_q(serial_abort_q), .serial0_active_q(serial0_active_q),
    .port_zero_a_input_q(port_zero_a_input_q), .enable_reset_q(enable_reset_q),
    .power_on_reset_q(power_on_reset_q), .pfd_en_q(pfd_en_q), .power_fail(power_fail),
    .stop_nop_q(stop_nop_q), .halt_state_q(halt_state_q), .stop_state_q(stop_state_q));

  assign lv = {cpu_run_q, periph_run_q, osc_en_q, port_zero_a_input_q, stop_state_q, halt_state_q, pfd_en_q};

  // Pulses last one cycle, so count them instead of timing them
  always @(posedge core_clk) begin
    n_ctrl   <= n_ctrl + 8'(ctrl_init_q === 1'h1);
    n_abort  <= n_abort + 8'(serial_abort_q === 1'h1);
    n_ereset <= n_ereset + 8'(enable_reset_q === 1'h1);
    n_por    <= n_por + 8'(power_on_reset_q === 1'h1);
    n_nop    <= n_nop + 8'(stop_nop_q === 1'h1);
  end

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic [6:0] lv_exp(input logic stop, input logic halt, input logic pfd);
    return {!stop && !halt, !stop, !stop, stop, stop, halt, pfd};
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic fire(input int k);
    @(posedge core_clk);
    case (k)
      0: stop_req <= 1'h1;
      1: halt_req <= 1'h1;
      2: serial0_irq_accept <= 1'h1;
      3: halt_release_event <= 1'h1;
      4: serial0_transfer_trigger <= 1'h1;
      5: btm0_carry_set <= 1'h1;
      6: serial0_done <= 1'h1;
      default: begin
        stop_req <= 1'h1;
        halt_req <= 1'h1;
      end
    endcase
    @(posedge core_clk);
    {stop_req, halt_req, serial0_irq_accept, halt_release_event, serial0_transfer_trigger} <= 5'h0;
    {btm0_carry_set, serial0_done} <= 2'h0;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // Synchroniser delay means the old state must still show as the pin lands
  task automatic set_ce(input logic v, input logic [6:0] hold);
    int i;
    @(posedge core_clk);
    ce_delay <= 4'($urandom_range(9, 0));
    ce_req   <= v;
    for (i = 0; i < 40 && chip_enable !== v; i++) @(negedge core_clk);
    if (i == 40) begin
      mismatches++;
      conclude();
    end
    chk(lv, hold);
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    conclude();
  end

  initial begin
    void'($urandom(54));
    repeat (6) @(posedge core_clk);
    nrst <= 1'h1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk(lv, lv_exp(1'h0, 1'h0, 1'h1));
    fire(4);
    fire(1);
    chk(lv, lv_exp(1'h0, 1'h1, 1'h1));
    chk({serial0_active_q, n_ctrl[6:0]}, 8'h80);
    fire(2);
    chk(lv, lv_exp(1'h0, 1'h0, 1'h1));
    for (int i = 0; i < 8; i++) begin
      fire(1);
      repeat ($urandom_range(3, 0)) @(posedge core_clk);
      @(negedge core_clk);
      chk(lv, lv_exp(1'h0, 1'h1, 1'h1));
      fire(2 + ($urandom & 1));
      chk(lv, lv_exp(1'h0, 1'h0, 1'h1));
    end
    fire(6);
    chk(serial0_active_q, 1'h0);
    fire(4);
    chk(serial0_active_q, 1'h1);
    fire(7);
    chk(lv, lv_exp(1'h1, 1'h0, 1'h0));
    chk({serial0_active_q, n_ctrl[2:0], n_abort[3:0]}, 8'h11);
    fire(1);
    chk(lv, lv_exp(1'h1, 1'h0, 1'h0));
    @(posedge core_clk);
    vdd_low <= 1'h1;
    vdd_ok  <= 1'h0;
    repeat (4) @(negedge core_clk);
    chk(power_fail, 1'h0);
    @(posedge core_clk);
    vdd_low <= 1'h0;
    vdd_ok  <= 1'h1;
    repeat (5) @(negedge core_clk);
    chk(lv, lv_exp(1'h0, 1'h0, 1'h1));
    chk(n_por, 8'h1);
    @(posedge core_clk);
    vdd_low <= 1'h1;
    repeat (4) @(negedge core_clk);
    chk(power_fail, 1'h1);
    @(posedge core_clk);
    vdd_low <= 1'h0;
    repeat (5) @(negedge core_clk);
    fire(0);
    set_ce(1'h1, lv_exp(1'h1, 1'h0, 1'h0));
    chk(lv, lv_exp(1'h0, 1'h0, 1'h0));
    chk(n_ereset, 8'h1);
    fire(0);
    chk(lv, lv_exp(1'h0, 1'h0, 1'h0));
    chk({n_nop[3:0], n_ereset[3:0]}, 8'h11);
    chk(n_ctrl, 8'h2);
    fire(5);
    chk(n_ereset, 8'h2);
    // Chip enable dropping in wait must not give a third enable reset
    fire(0);
    set_ce(1'h0, lv_exp(1'h0, 1'h0, 1'h0));
    chk({n_nop[3:0], n_ereset[3:0]}, 8'h22);
    chk(lv, lv_exp(1'h0, 1'h0, 1'h0));
    conclude();
  end
endmodule // halt_clock_stop_control_tb
